// File: bench/e1im_host_model.sv
// Host side of the shared interrupt request: open-drain line with pull-up.
// Assumes the device drives its constant pin value only while enabled.
`timescale 1ns/1ps
module e1im_host_model (
    input  wire logic irq_n_o,
    input  wire logic irq_n_oe,
    output logic      irq_line
);
    // Released or suspended pin floats up to the pull-up level
    assign irq_line = irq_n_oe ? irq_n_o : 1'h1;
endmodule : e1im_host_model

// File: bench/test_e1_framer_interrupt_masks.sv
// Self-checking bench for the E1 receive event mask block.
// Assumes the host model resolves the open-drain request line.
`timescale 1ns/1ps
module test_e1_framer_interrupt_masks
    import e1im_pkg::*;
;
    typedef struct packed {
        logic       lvl;
        logic [3:0] idx;
        logic [1:0] word;
        logic [2:0] bitn;
    } e1im_row_type;

    logic           clk;
    logic           arst_n;
    logic           bus_wr;
    logic           bus_rd;
    logic [7:0]     bus_page;
    logic [4:0]     bus_addr;
    logic [7:0]     bus_wdata;
    logic [7:0]     bus_rdata;
    e1im_level_type levels;
    e1im_pulse_type pulses;
    logic           irq_n_o;
    logic           irq_n_oe;
    logic           irq_line;
    logic           ack_tg;
    logic           susp;
    logic [7:0]     v;
    logic [4:0]     a;
    logic [7:0]     m;
    int             err_count;
    int             checked;
    // Event source, its mask word and bit; flag expected at the same bit
    e1im_row_type   rows [20] = '{
        '{1'h1, 4'h0, 2'h0, 3'h7}, '{1'h1, 4'h1, 2'h0, 3'h6}, '{1'h1, 4'h2, 2'h0, 3'h5},
        '{1'h1, 4'h3, 2'h0, 3'h4}, '{1'h1, 4'h4, 2'h0, 3'h3}, '{1'h1, 4'h5, 2'h0, 3'h1},
        '{1'h1, 4'h6, 2'h1, 3'h1}, '{1'h0, 4'hc, 2'h0, 3'h2}, '{1'h0, 4'hb, 2'h0, 3'h0},
        '{1'h0, 4'ha, 2'h1, 3'h7}, '{1'h0, 4'h9, 2'h1, 3'h6}, '{1'h0, 4'h8, 2'h1, 3'h5},
        '{1'h0, 4'h7, 2'h1, 3'h4}, '{1'h0, 4'h6, 2'h1, 3'h3}, '{1'h0, 4'h5, 2'h1, 3'h2},
        '{1'h0, 4'h4, 2'h1, 3'h0}, '{1'h0, 4'h3, 2'h2, 3'h7}, '{1'h0, 4'h2, 2'h2, 3'h6},
        '{1'h0, 4'h1, 2'h2, 3'h5}, '{1'h0, 4'h0, 2'h2, 3'h3}};

    e1im_top DUT (
        .CLK(clk), .ARST_N(arst_n), .BUS_WR(bus_wr), .BUS_RD(bus_rd),
        .BUS_PAGE(bus_page), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata),
        .BUS_RDATA(bus_rdata), .LEVELS(levels), .PULSES(pulses),
        .IRQ_N_O(irq_n_o), .IRQ_N_OE(irq_n_oe));

    e1im_host_model host (.irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .irq_line(irq_line));

    // Free-running 125 MHz clock
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    // One write strobe, optionally with event pulses in the same cycle
    task automatic wr_ev(input logic [7:0] pg, input logic [4:0] ad, input logic [7:0] d,
                         input e1im_pulse_type p);
        @(posedge clk);
        bus_wr    <= 1'h1;
        bus_page  <= pg;
        bus_addr  <= ad;
        bus_wdata <= d;
        pulses    <= p;
        @(posedge clk);
        bus_wr    <= 1'h0;
        pulses    <= '0;
    endtask : wr_ev

    task automatic wr(input logic [7:0] pg, input logic [4:0] ad, input logic [7:0] d);
        wr_ev(pg, ad, d, '0);
    endtask : wr

    task automatic rd(input logic [7:0] pg, input logic [4:0] ad, output logic [7:0] d);
        @(posedge clk);
        bus_rd   <= 1'h1;
        bus_page <= pg;
        bus_addr <= ad;
        @(posedge clk);
        bus_rd   <= 1'h0;
        #1;
        d = bus_rdata;
    endtask : rd

    function automatic logic [7:0] ctrlv();
        return {1'h0, susp, ack_tg, 5'h00};
    endfunction : ctrlv

    function automatic logic [7:0] irqv();
        return {7'h00, irq_line};
    endfunction : irqv

    task automatic ctrl_wr();
        wr(MASK_PAGE, CTRL_ADDR, ctrlv());
    endtask : ctrl_wr

    task automatic ack();
        ack_tg = ~ack_tg;
        ctrl_wr();
    endtask : ack

    // A level changes twice, a pulse lasts one cycle
    task automatic ev(input e1im_row_type r);
        @(posedge clk);
        if (r.lvl) begin
            levels[r.idx] <= ~levels[r.idx];
            tick(3);
            levels[r.idx] <= ~levels[r.idx];
        end else begin
            pulses[r.idx] <= 1'h1;
            @(posedge clk);
            pulses[r.idx] <= 1'h0;
        end
    endtask : ev

    // Watchdog far beyond the expected run length
    initial begin
        tick(20000);
        err_count++;
        close_out();
    end

    // Main sequence
    initial begin
        {arst_n, bus_wr, bus_rd, bus_page, bus_addr, bus_wdata} = '0;
        levels = '0;
        pulses = '0;
        {ack_tg, susp, err_count, checked} = '0;
        tick(16);
        check("rdata reset", 8'h00, bus_rdata);
        check("irq reset", 8'h01, irqv());
        arst_n <= 1'h1;
        for (int w = 0; w < 3; w++) begin
            rd(MASK_PAGE, MASK0_ADDR + 5'(w), v);
            check("mask reset", 8'h00, v);
            wr(MASK_PAGE, MASK0_ADDR + 5'(w), 8'hff);
            rd(MASK_PAGE, MASK0_ADDR + 5'(w), v);
            check("mask ones", (w == 2) ? 8'he8 : 8'hff, v);
            wr(MASK_PAGE, MASK0_ADDR + 5'(w), 8'h00);
        end
        rd(MASK_PAGE, 5'h10, v);
        check("unmapped", 8'h00, v);
        $display("test registers done");
        for (int i = 0; i < 20; i++) begin
            a = MASK0_ADDR + 5'(rows[i].word);
            m = 8'h01 << rows[i].bitn;
            ack();
            ev(rows[i]);
            tick(4);
            check("irq masked", 8'h01, irqv());
            rd(EVENT_PAGE, a, v);
            check("flag", m, v);
            wr(MASK_PAGE, a, m);
            ack();
            ev(rows[i]);
            tick(4);
            check("irq", 8'h00, irqv());
            ack();
            tick(2);
            check("irq ack", 8'h01, irqv());
            wr(MASK_PAGE, a, 8'h00);
        end
        $display("test event table done");
        wr(MASK_PAGE, MASK0_ADDR, 8'h01);
        susp = 1'h1;
        ctrl_wr();
        rd(MASK_PAGE, CTRL_ADDR, v);
        check("ctrl", {2'h1, ack_tg, 5'h00}, v);
        ev(rows[8]);
        tick(4);
        check("irq suspended", 8'h01, irqv());
        susp = 1'h0;
        ctrl_wr();
        tick(3);
        check("irq ignored", 8'h01, irqv());
        ev(rows[8]);
        tick(4);
        check("irq", 8'h00, irqv());
        susp = 1'h1;
        ctrl_wr();
        tick(3);
        check("irq float", 8'h01, irqv());
        susp = 1'h0;
        ctrl_wr();
        tick(3);
        check("irq redrive", 8'h00, irqv());
        $display("test suspend done");
        ack_tg = ~ack_tg;
        wr_ev(MASK_PAGE, CTRL_ADDR, ctrlv(), e1im_pulse_type'(13'h0800));
        tick(3);
        check("event beats ack", 8'h00, irqv());
        ack();
        wr(MASK_PAGE, MASK1_ADDR, 8'h09);
        @(posedge clk);
        pulses <= e1im_pulse_type'(13'h0040);
        @(posedge clk);
        pulses <= e1im_pulse_type'(13'h0010);
        @(posedge clk);
        pulses <= '0;
        tick(3);
        check("irq or", 8'h00, irqv());
        ack();
        tick(2);
        check("irq one ack", 8'h01, irqv());
        $display("test ack order done");
        wr(MASK_PAGE, MASK1_ADDR, 8'h02);
        levels.aux_pattern_status <= 1'h1;
        tick(4);
        ack();
        levels.aux_pattern_status <= 1'h0;
        tick(4);
        check("aux fall", 8'h01, irqv());
        $display("test aux fall done");
        ev(rows[6]);
        tick(2);
        check("irq before reset", 8'h00, irqv());
        @(posedge clk);
        arst_n <= 1'h0;
        tick(2);
        arst_n <= 1'h1;
        ack_tg = 1'h0;
        rd(MASK_PAGE, MASK1_ADDR, v);
        check("mask after reset", 8'h00, v);
        check("irq after reset", 8'h01, irqv());
        $display("test mid reset done");
        close_out();
    end
endmodule : test_e1_framer_interrupt_masks

// File: rtl/e1im_byte_reg.sv
// One host-writable byte with a fixed set of writable bits.
// Assumes write strobe and data are synchronous to CLK.
`timescale 1ns/1ps
module e1im_byte_reg
    import e1im_pkg::*;
#(
    parameter logic [7:0] WMASK = 8'hff,
    parameter logic [7:0] RESET = MASK_RESET
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       wr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] q,
    output logic      [7:0] q_next
);
    logic [7:0] value_reg;
    logic [7:0] value_next;

    // Writes touch only the writable bits
    always_comb begin
        value_next = value_reg;
        if (wr) begin
            value_next = wdata & WMASK;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            value_reg <= RESET & WMASK;
        end else begin
            value_reg <= value_next;
        end
    end

    assign q      = value_reg;
    assign q_next = value_next;
endmodule : e1im_byte_reg

// File: rtl/e1im_edge_detect.sv
// Change and rising-edge detector for a group of status levels.
// Assumes the levels are synchronous to CLK; output pulses are registered.
`timescale 1ns/1ps
module e1im_edge_detect
    import e1im_pkg::*;
#(
    parameter int             WIDTH     = LEVEL_N,
    parameter logic [WIDTH-1:0] RISE_ONLY = LEVEL_RISE_ONLY
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] pulse
);
    logic [WIDTH-1:0] last_reg;
    logic [WIDTH-1:0] last_next;
    logic [WIDTH-1:0] pulse_reg;
    logic [WIDTH-1:0] pulse_next;

    // Any change, or a rise only where selected
    always_comb begin
        last_next  = level;
        pulse_next = (level ^ last_reg) & (level | ~RISE_ONLY);
    end

    // Previous level and pulse registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_reg  <= '0;
            pulse_reg <= '0;
        end else begin
            last_reg  <= last_next;
            pulse_reg <= pulse_next;
        end
    end

    assign pulse = pulse_reg;
endmodule : e1im_edge_detect

// File: rtl/e1im_pkg.sv
// Constants and carrier types for the E1 receive event mask block.
// Assumes one 125 MHz clock and event inputs synchronous to it.
package e1im_pkg;
    // Register bus widths
    localparam int ADDR_W = 5;
    localparam int PAGE_W = 8;
    localparam int DATA_W = 8;

    // Register pages and addresses
    localparam logic [7:0] MASK_PAGE  = 8'h01;
    localparam logic [7:0] EVENT_PAGE = 8'h0f;
    localparam logic [4:0] CTRL_ADDR  = 5'h1a;
    localparam logic [4:0] MASK0_ADDR = 5'h1b;
    localparam logic [4:0] MASK1_ADDR = 5'h1c;
    localparam logic [4:0] MASK2_ADDR = 5'h1d;

    // Control word field positions
    localparam int SUSPEND_BIT = 6;
    localparam int ACK_BIT     = 5;

    // Writable bits of each word, unused bits read zero
    localparam logic [7:0] CTRL_WMASK  = 8'h60;
    localparam logic [7:0] MASK0_WMASK = 8'hff;
    localparam logic [7:0] MASK1_WMASK = 8'hff;
    localparam logic [7:0] MASK2_WMASK = 8'he8;

    // Reset values
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Number of watched status levels and their edge modes (1 = rise only)
    localparam int         LEVEL_N         = 7;
    localparam logic [6:0] LEVEL_RISE_ONLY = 7'h40;

    // Status levels whose changes are events
    typedef struct packed {
        logic aux_pattern_status;
        logic remote_sig_mf_alarm;
        logic signal_loss;
        logic alarm_signal;
        logic crc_multiframe_sync;
        logic multiframe_sync;
        logic frame_sync_change_status;
    } e1im_level_type;

    // One-cycle event pulses from the detectors and counters
    typedef struct packed {
        logic double_errored_alignment;
        logic frame_slip;
        logic alignment_error;
        logic local_checksum_error;
        logic remote_error_bit;
        logic channel16_alarm;
        logic bipolar_violation;
        logic pattern_check_error;
        logic remote_alarm;
        logic alignment_count_overflow;
        logic checksum_count_overflow;
        logic remote_error_count_overflow;
        logic violation_count_wrap;
    } e1im_pulse_type;

    // Three mask words as one carrier
    typedef struct packed {
        logic [7:0] word2;
        logic [7:0] word1;
        logic [7:0] word0;
    } e1im_masks_type;
endpackage : e1im_pkg

// File: rtl/e1im_top.sv
// Receive event masking and shared interrupt request for the E1 framer.
// Assumes a synchronous host port and event inputs synchronous to CLK.
`timescale 1ns/1ps
// How it works
// - A mask bit of one lets its event interrupt; zero blocks it.
// - Word zero bit 7 enables interrupt on frame sync change.
// - Word zero bits 6 and 5 enable multiframe and CRC multiframe sync changes.
// - Word zero bit 4 enables interrupt on alarm signal change.
// - Word zero bit 3 enables interrupt on loss of signal change.
// - Word zero bit 2 enables interrupt on two errored alignment signals.
// - Word zero bit 1 enables interrupt on remote multiframe alarm change.
// - Word zero bit 0 enables interrupt on each controlled slip.
// - Word one bit 7 enables interrupt on each alignment signal error.
// - Word one bit 6 enables interrupt on each local CRC error.
// - Word one bit 5 enables interrupt on remote CRC error E-bit.
// - Word one bit 4 enables interrupt on channel 16 alarm.
// - Word one bit 3 enables interrupt on each bipolar violation.
// - Word one bit 2 enables interrupt on each pattern checker error.
// - Word one bit 1 enables interrupt when auxiliary pattern status rises.
// - Word one bit 0 enables interrupt on remote alarm reception.
// - Word two bit 7 enables interrupt on alignment error counter overflow.
// - Word two bit 6 enables interrupt on CRC error counter overflow.
// - Word two bit 5 enables E-bit counter overflow; bit 4 unused.
// - Word two bit 3 enables interrupt on violation counter wrap.
// - Suspend bit floats the request and ignores all sources.
// - Toggling the acknowledge bit clears pending and floats the request, except when an unmasked event hits in the same cycle.
module e1im_top
    import e1im_pkg::*;
(
    input  wire logic              CLK,
    input  wire logic              ARST_N,
    input  wire logic              BUS_WR,
    input  wire logic              BUS_RD,
    input  wire logic [PAGE_W-1:0] BUS_PAGE,
    input  wire logic [ADDR_W-1:0] BUS_ADDR,
    input  wire logic [DATA_W-1:0] BUS_WDATA,
    output logic      [DATA_W-1:0] BUS_RDATA,
    input  wire e1im_level_type    LEVELS,
    input  wire e1im_pulse_type    PULSES,
    output logic                   IRQ_N_O,
    output logic                   IRQ_N_OE
);
    e1im_masks_type   masks;
    logic [7:0]       ctrl_q;
    logic [7:0]       ctrl_q_next;
    logic [LEVEL_N-1:0] level_pulse;
    logic [23:0]      ev_vec;
    logic [23:0]      flags_reg;
    logic [23:0]      flags_next;
    logic             pend_reg;
    logic             pend_next;
    logic             oe_reg;
    logic             oe_next;
    logic [7:0]       rdata_reg;
    logic [7:0]       rdata_next;
    logic             hit;
    logic             ack;
    logic             wr_mask_page;
    logic             susp_reg;

    // Register select for a write on the mask page
    function automatic logic sel(input logic [4:0] addr, input logic [4:0] target);
        sel = (addr == target);
    endfunction : sel

    assign wr_mask_page = BUS_WR && (BUS_PAGE == MASK_PAGE);

    // Control word: suspend and acknowledge bits
    e1im_byte_reg #(
        .WMASK (CTRL_WMASK),
        .RESET (CTRL_RESET)
    ) u_ctrl (
        .clk    (CLK),
        .arst_n (ARST_N),
        .wr     (wr_mask_page && sel(BUS_ADDR, CTRL_ADDR)),
        .wdata  (BUS_WDATA),
        .q      (ctrl_q),
        .q_next (ctrl_q_next)
    );

    // Mask word zero
    e1im_byte_reg #(
        .WMASK (MASK0_WMASK),
        .RESET (MASK_RESET)
    ) u_mask0 (
        .clk    (CLK),
        .arst_n (ARST_N),
        .wr     (wr_mask_page && sel(BUS_ADDR, MASK0_ADDR)),
        .wdata  (BUS_WDATA),
        .q      (masks.word0),
        .q_next ()
    );

    // Mask word one
    e1im_byte_reg #(
        .WMASK (MASK1_WMASK),
        .RESET (MASK_RESET)
    ) u_mask1 (
        .clk    (CLK),
        .arst_n (ARST_N),
        .wr     (wr_mask_page && sel(BUS_ADDR, MASK1_ADDR)),
        .wdata  (BUS_WDATA),
        .q      (masks.word1),
        .q_next ()
    );

    // Mask word two, bit 4 and the low bits stay zero
    e1im_byte_reg #(
        .WMASK (MASK2_WMASK),
        .RESET (MASK_RESET)
    ) u_mask2 (
        .clk    (CLK),
        .arst_n (ARST_N),
        .wr     (wr_mask_page && sel(BUS_ADDR, MASK2_ADDR)),
        .wdata  (BUS_WDATA),
        .q      (masks.word2),
        .q_next ()
    );

    // Suspend as stored in the control word
    assign susp_reg = ctrl_q[SUSPEND_BIT];
    // Acknowledge is any change of the acknowledge bit
    assign ack = ctrl_q_next[ACK_BIT] ^ ctrl_q[ACK_BIT];

    // Change detection on status levels, rise only for auxiliary pattern
    e1im_edge_detect #(
        .WIDTH     (LEVEL_N),
        .RISE_ONLY (LEVEL_RISE_ONLY)
    ) u_edges (
        .clk    (CLK),
        .arst_n (ARST_N),
        .level  (LEVELS),
        .pulse  (level_pulse)
    );

    // Event vector laid out like the mask words
    always_comb begin
        ev_vec     = '0;
        ev_vec[7]  = level_pulse[0];
        ev_vec[6]  = level_pulse[1];
        ev_vec[5]  = level_pulse[2];
        ev_vec[4]  = level_pulse[3];
        ev_vec[3]  = level_pulse[4];
        ev_vec[2]  = PULSES.double_errored_alignment;
        ev_vec[1]  = level_pulse[5];
        ev_vec[0]  = PULSES.frame_slip;
        ev_vec[15] = PULSES.alignment_error;
        ev_vec[14] = PULSES.local_checksum_error;
        ev_vec[13] = PULSES.remote_error_bit;
        ev_vec[12] = PULSES.channel16_alarm;
        ev_vec[11] = PULSES.bipolar_violation;
        ev_vec[10] = PULSES.pattern_check_error;
        ev_vec[9]  = level_pulse[6];
        ev_vec[8]  = PULSES.remote_alarm;
        ev_vec[23] = PULSES.alignment_count_overflow;
        ev_vec[22] = PULSES.checksum_count_overflow;
        ev_vec[21] = PULSES.remote_error_count_overflow;
        ev_vec[19] = PULSES.violation_count_wrap;
    end

    // Pending request, event flags and pin enable
    always_comb begin
        hit        = (|(ev_vec & masks)) && !susp_reg;
        flags_next = ev_vec | (flags_reg & {24{~ack}});
        pend_next  = hit || (pend_reg && !ack);
        oe_next    = pend_next && !ctrl_q_next[SUSPEND_BIT];
    end

    // Read path, unmapped addresses answer zero
    always_comb begin
        rdata_next = rdata_reg;
        if (BUS_RD) begin
            rdata_next = 8'h00;
            if (BUS_PAGE == MASK_PAGE) begin
                case (BUS_ADDR)
                    CTRL_ADDR:  rdata_next = ctrl_q;
                    MASK0_ADDR: rdata_next = masks.word0;
                    MASK1_ADDR: rdata_next = masks.word1;
                    MASK2_ADDR: rdata_next = masks.word2;
                    default:    rdata_next = 8'h00;
                endcase
            end else if (BUS_PAGE == EVENT_PAGE) begin
                case (BUS_ADDR)
                    MASK0_ADDR: rdata_next = flags_reg[7:0];
                    MASK1_ADDR: rdata_next = flags_reg[15:8];
                    MASK2_ADDR: rdata_next = flags_reg[23:16];
                    default:    rdata_next = 8'h00;
                endcase
            end
        end
    end

    // State registers
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            flags_reg <= '0;
            pend_reg  <= 1'b0;
            oe_reg    <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            flags_reg <= flags_next;
            pend_reg  <= pend_next;
            oe_reg    <= oe_next;
            rdata_reg <= rdata_next;
        end
    end

    assign BUS_RDATA = rdata_reg;
    assign IRQ_N_OE  = oe_reg;
    assign IRQ_N_O   = 1'h0; // Open drain, only pulls low

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    a_event_raises_irq: assert property (
        (|(ev_vec & masks)) && !susp_reg |=> pend_reg)
        else $error("Unmasked event did not set pending");

    a_masked_blocked: assert property (
        !pend_reg && ((ev_vec & masks) == 24'h000000) |=> !pend_reg)
        else $error("Pending set without unmasked event");

    a_suspend_floats: assert property (
        susp_reg |-> !IRQ_N_OE)
        else $error("Request driven while suspended");

    a_ack_clears: assert property (
        ack && !hit |=> !pend_reg && !IRQ_N_OE)
        else $error("Acknowledge did not clear request");

    a_sync_change: assert property (
        $changed(LEVELS.frame_sync_change_status) && masks.word0[7] && !susp_reg
        && $stable(ctrl_q) |=> ##1 pend_reg)
        else $error("Frame sync change did not interrupt");

    a_aux_rise: assert property (
        !pend_reg && ((ev_vec & masks) == 24'h000000) && $fell(LEVELS.aux_pattern_status)
        && (masks == 24'h000200) |=> ##1 !pend_reg)
        else $error("Auxiliary pattern fall raised interrupt");

    a_wrap_irq: assert property (
        PULSES.violation_count_wrap && masks.word2[3] && !susp_reg
        && !ctrl_q_next[SUSPEND_BIT] |=> IRQ_N_OE)
        else $error("Violation counter wrap did not interrupt");

    a_unused_zero: assert property (
        (masks.word2 & 8'h17) == 8'h00 && (ctrl_q & 8'h9f) == 8'h00)
        else $error("Unused mask bits not zero");

    a_slip_irq: assert property (
        PULSES.frame_slip && masks.word0[0] && !susp_reg |=> pend_reg)
        else $error("Slip did not interrupt");

    // Suspend, acknowledge, flags, level change interrupts and register access
    a_suspend_ignores: assert property (
        susp_reg && !pend_reg |=> !pend_reg)
        else $error("Event accepted while suspended");

    a_ack_clears_flags: assert property (
        ack && (ev_vec == 24'h000000) |=> flags_reg == 24'h000000)
        else $error("Acknowledge did not clear event flags");

    a_flags_capture: assert property (
        ev_vec != 24'h000000 |=> (flags_reg & $past(ev_vec)) == $past(ev_vec))
        else $error("Event flag not captured");

    a_mask_write: assert property (
        wr_mask_page && sel(BUS_ADDR, MASK1_ADDR)
        |=> masks.word1 == $past(BUS_WDATA))
        else $error("Mask word one write lost");

    a_unused_ignored: assert property (
        wr_mask_page && sel(BUS_ADDR, MASK2_ADDR)
        |=> masks.word2 == ($past(BUS_WDATA) & 8'he8))
        else $error("Mask word two write not filtered");

    a_loss_change: assert property (
        $changed(LEVELS.signal_loss) && masks.word0[3] && !susp_reg
        && !ctrl_q_next[SUSPEND_BIT] && !wr_mask_page |=> ##1 pend_reg)
        else $error("Loss of signal change did not interrupt");

    a_aux_rise_irq: assert property (
        $rose(LEVELS.aux_pattern_status) && masks.word1[1] && !susp_reg
        && !ctrl_q_next[SUSPEND_BIT] && !wr_mask_page |=> ##1 pend_reg)
        else $error("Auxiliary pattern rise did not interrupt");

    a_rdata_hold: assert property (
        !BUS_RD |=> $stable(BUS_RDATA))
        else $error("Read data changed without a read");

    a_mask_readback: assert property (
        BUS_RD && (BUS_PAGE == MASK_PAGE) && sel(BUS_ADDR, MASK0_ADDR)
        |=> BUS_RDATA == $past(masks.word0))
        else $error("Mask word zero read back wrong");

    a_irq_needs_pend: assert property (
        IRQ_N_OE |-> pend_reg)
        else $error("Request driven with nothing pending");

    c_irq_seen: cover property (!IRQ_N_OE ##1 IRQ_N_OE);
    c_ack_seen: cover property (pend_reg && ack ##1 !pend_reg);
    c_suspend_hold: cover property (pend_reg && susp_reg);
    c_event_beats_ack: cover property (ack && hit);
    c_level_event: cover property ((|level_pulse) ##1 pend_reg);
endmodule : e1im_top
